// file: src/lin_sbc_mode_wake_control.sv
/*
 mode, wake, transmit gating, reset output and watchdog control of a
 LIN system basis chip, with an AXI4-Lite register slave.
 assumes pins synchronous to aclk; aclk stands for the internal
 oscillator; battery_ok low means supply below the undervoltage level.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lin_sbc_map.svh"
// Operation
// - supply up enters Standby, enable ignored
// - logic held reset while supply undervoltage
// - enable fall leaves Normal, rise requests Normal
// - Normal after entry delay, held while enabled and vcc_ok high
// - Standby to Normal on enable rise
// - enable passes through debounce filter
// - enable rise clears wake interrupt and flag
// - transmit input low drives bus dominant
// - undriven transmit input reads high
// - transmit path enabled once input seen high
// - dominant counter starts on first dominant
// - dominant too long disables transmit path
// - negative transmit edge resets dominant counter
// - reset output shows supply and watchdog faults
// - reset output held 4 ms after supply fault, 2 watchdog ticks after watchdog fault
// - supply inhibit on in Standby and Normal
// - local wake fall wakes Silent or Sleep
// - open local wake input reads high
// - ignition rise wakes; open ignition reads low
// - trigger fall in open window restarts watchdog
// - watchdog off while mode input high
// - watchdog times from configurable unit register
// - enable fall enters Silent or Sleep by transmit
// - Standby without enable rise times out to Sleep
// - wake into Standby pulls receive pin low
// - first enable rise picks slew from transmit
module lin_sbc_mode_wake_control #(
   parameter logic [25:0] POR_CYCLES  = 26'(`POR_CYCLES),
   parameter logic [25:0] STBY_CYCLES = 26'(`STBY_CYCLES),
   parameter logic [25:0] DOM_CYCLES  = 26'(`DOM_CYCLES),
   parameter logic [25:0] WU_CYCLES   = 26'(`WU_CYCLES)
) (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire lin_sbc_pkg::pins_in_t    pins_i,
   input  wire lin_sbc_pkg::axil_req_t   axi_req,
   output var  lin_sbc_pkg::pins_out_t   pins_o,
   output var  lin_sbc_pkg::axil_rsp_t   axi_rsp
);
   localparam logic [25:0] NORM_CYCLES = 26'(`NORM_CYCLES);

   function automatic logic rose(input logic q, input logic d);
      return !q && d;
   endfunction

   function automatic logic fell(input logic q, input logic d);
      return q && !d;
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[i*8 +: 8] = dat[i*8 +: 8];
      end
      return r;
   endfunction

   function automatic lin_sbc_pkg::sbc_state_t rst_val();
      lin_sbc_pkg::sbc_state_t r;
      r = '0;
      r.mode = lin_sbc_pkg::M_INIT;
      r.variant = `CTRL_RST;
      r.wd_unit = `WD_UNIT_RST;
      r.pins.reset_oe = 1'b1;
      r.rsp.awready = 1'b1;
      r.rsp.wready = 1'b1;
      r.rsp.arready = 1'b1;
      return r;
   endfunction

   localparam lin_sbc_pkg::sbc_state_t ST_RST = rst_val();

   lin_sbc_pkg::sbc_state_t st_ff, nxt_st;
   logic core_rst_n;
   logic en_db;
   logic wd_fault;
   logic wd_run;
   logic kick_fall;

   // undervoltage acts exactly like the system reset
   assign core_rst_n = aresetn && pins_i.battery_ok;

   en_debounce u_en_deb (
      .aclk  (aclk),
      .rst_n (core_rst_n),
      .din   (pins_i.enable_in),
      .dout  (en_db)
   );

   // watchdog only in Standby, the Normal entry delay and Normal, after power-on reset
   assign wd_run = st_ff.variant && !pins_i.wdog_mode_in
                && st_ff.por_cnt == POR_CYCLES
                && (st_ff.mode == lin_sbc_pkg::M_STANDBY
                 || st_ff.mode == lin_sbc_pkg::M_NORM_WAIT
                 || st_ff.mode == lin_sbc_pkg::M_NORMAL);
   assign kick_fall = fell(st_ff.kick_q, pins_i.wdog_kick_n);

   window_watchdog u_wd (
      .aclk      (aclk),
      .rst_n     (core_rst_n),
      .run       (wd_run),
      .kick      (kick_fall),
      .unit      (st_ff.wd_unit),
      .fault_rst (wd_fault)
   );

   always_comb begin
      logic txd_h;
      logic lw;
      logic ign;
      logic en_rise;
      logic en_fall;
      logic rwake;
      logic lwake;
      logic wake;
      logic [31:0] rd;
      logic rd_ok;
      txd_h = 1'b0;
      lw = 1'b0;
      ign = 1'b0;
      en_rise = 1'b0;
      en_fall = 1'b0;
      rwake = 1'b0;
      lwake = 1'b0;
      wake = 1'b0;
      rd = 32'h00000000;
      rd_ok = 1'b0;
      nxt_st = st_ff;

      txd_h = pins_i.txd_i || pins_i.txd_undriven;
      lw = pins_i.local_wake_in || pins_i.local_wake_open;
      ign = pins_i.ignition_wake_in && !pins_i.ignition_open;
      en_rise = rose(st_ff.en_q, en_db);
      en_fall = fell(st_ff.en_q, en_db);
      nxt_st.en_q = en_db;
      nxt_st.txd_q = txd_h;
      nxt_st.lw_q = lw;
      nxt_st.ign_q = ign;
      nxt_st.lin_q = pins_i.lin_bus_in;
      nxt_st.kick_q = pins_i.wdog_kick_n;

      // remote wake: dominant longer than the filter, then release
      if (fell(st_ff.lin_q, pins_i.lin_bus_in)) begin
         nxt_st.rw_cnt = 26'h0000000;
      end else if (!pins_i.lin_bus_in && st_ff.rw_cnt != WU_CYCLES) begin
         nxt_st.rw_cnt = st_ff.rw_cnt + 26'h0000001;
      end
      rwake = rose(st_ff.lin_q, pins_i.lin_bus_in)
           && st_ff.rw_cnt == WU_CYCLES;
      lwake = st_ff.variant && (fell(st_ff.lw_q, lw)
                             || rose(st_ff.ign_q, ign));
      wake = rwake || lwake;

      nxt_st.tmr = st_ff.tmr + 26'h0000001;
      case (st_ff.mode)
         lin_sbc_pkg::M_INIT: begin
            nxt_st.mode = lin_sbc_pkg::M_STANDBY;
         end
         lin_sbc_pkg::M_STANDBY: begin
            if (en_rise) begin
               nxt_st.mode = lin_sbc_pkg::M_NORM_WAIT;
            end else if (st_ff.tmr == STBY_CYCLES - 26'h0000001) begin
               nxt_st.mode = lin_sbc_pkg::M_SLEEP;
            end
         end
         lin_sbc_pkg::M_NORM_WAIT: begin
            if (!en_db) begin
               nxt_st.mode = lin_sbc_pkg::M_STANDBY;
            end else if (st_ff.tmr == NORM_CYCLES - 26'h0000001) begin
               nxt_st.mode = lin_sbc_pkg::M_NORMAL;
            end
         end
         lin_sbc_pkg::M_NORMAL: begin
            if (en_fall) begin
               nxt_st.mode = txd_h ? lin_sbc_pkg::M_SILENT
                                   : lin_sbc_pkg::M_SLEEP;
            end else if (!pins_i.vcc_ok) begin
               nxt_st.mode = lin_sbc_pkg::M_STANDBY;
            end
         end
         lin_sbc_pkg::M_SILENT: begin
            if (en_rise) begin
               nxt_st.mode = lin_sbc_pkg::M_NORM_WAIT;
            end else if (wake || !pins_i.vcc_ok) begin
               nxt_st.mode = lin_sbc_pkg::M_STANDBY;
            end
         end
         lin_sbc_pkg::M_SLEEP: begin
            if (wake) nxt_st.mode = lin_sbc_pkg::M_STANDBY;
         end
         default: nxt_st.mode = lin_sbc_pkg::M_INIT;
      endcase
      if (nxt_st.mode != st_ff.mode) nxt_st.tmr = 26'h0000000;

      // a wake in the same cycle as a clear keeps the flag
      if (wake && (st_ff.mode == lin_sbc_pkg::M_SILENT
                || st_ff.mode == lin_sbc_pkg::M_SLEEP)) begin
         nxt_st.wake_irq = 1'b1;
         nxt_st.wake_local = lwake;
      end else if ((en_rise && st_ff.variant)
                || nxt_st.mode == lin_sbc_pkg::M_NORMAL) begin
         nxt_st.wake_irq = 1'b0;
         nxt_st.wake_local = 1'b0;
      end

      if (en_rise && !st_ff.first_done) begin
         nxt_st.first_done = 1'b1;
         nxt_st.slew_low = !txd_h;
      end

      if (st_ff.mode != lin_sbc_pkg::M_NORMAL) begin
         nxt_st.tx_en = 1'b0;
         nxt_st.dom_cnt = 26'h0000000;
      end else if (!st_ff.tx_en) begin
         nxt_st.dom_cnt = 26'h0000000;
         if (txd_h) nxt_st.tx_en = 1'b1;
      end else if (fell(st_ff.txd_q, txd_h)) begin
         nxt_st.dom_cnt = 26'h0000001;
      end else if (!txd_h) begin
         nxt_st.dom_cnt = st_ff.dom_cnt + 26'h0000001;
         if (st_ff.dom_cnt >= DOM_CYCLES - 26'h0000001) begin
            nxt_st.tx_en = 1'b0;
         end
      end

      // reset output: supply fault restarts the power-on delay
      if (!pins_i.vcc_ok) begin
         nxt_st.por_cnt = 26'h0000000;
      end else if (st_ff.por_cnt != POR_CYCLES) begin
         nxt_st.por_cnt = st_ff.por_cnt + 26'h0000001;
      end

      nxt_st.pins.rxd_o = 1'b0;
      nxt_st.pins.txd_o = 1'b0;
      nxt_st.pins.reset_out_n = 1'b0;
      nxt_st.pins.reset_oe = (nxt_st.por_cnt != POR_CYCLES)
                          || wd_fault;
      nxt_st.pins.lin_dom = nxt_st.tx_en && !txd_h
                         && nxt_st.mode == lin_sbc_pkg::M_NORMAL;
      nxt_st.pins.lin_slew_low = nxt_st.slew_low;
      nxt_st.pins.supply_inhibit_out =
         nxt_st.mode == lin_sbc_pkg::M_STANDBY
         || nxt_st.mode == lin_sbc_pkg::M_NORM_WAIT
         || nxt_st.mode == lin_sbc_pkg::M_NORMAL;
      nxt_st.pins.vreg_on = nxt_st.mode != lin_sbc_pkg::M_SLEEP
                         && nxt_st.mode != lin_sbc_pkg::M_INIT;
      nxt_st.pins.rxd_oe =
         (nxt_st.mode == lin_sbc_pkg::M_NORMAL && !pins_i.lin_bus_in)
         || (nxt_st.mode == lin_sbc_pkg::M_STANDBY
             && nxt_st.wake_irq);
      nxt_st.pins.txd_oe = nxt_st.mode == lin_sbc_pkg::M_STANDBY
                        && nxt_st.wake_irq && nxt_st.wake_local;

      // write channel: address and data held until both are in
      if (axi_req.awvalid && st_ff.rsp.awready) begin
         nxt_st.awaddr = axi_req.awaddr;
         nxt_st.rsp.awready = 1'b0;
      end
      if (axi_req.wvalid && st_ff.rsp.wready) begin
         nxt_st.wdata = axi_req.wdata;
         nxt_st.wstrb = axi_req.wstrb;
         nxt_st.rsp.wready = 1'b0;
      end
      if (!st_ff.rsp.awready && !st_ff.rsp.wready
          && !st_ff.rsp.bvalid) begin
         nxt_st.rsp.bvalid = 1'b1;
         nxt_st.rsp.bresp = `RESP_OKAY;
         case (st_ff.awaddr)
            `REG_CTRL: begin
               if (st_ff.wstrb[0]) begin
                  nxt_st.variant = st_ff.wdata[`CTRL_VARIANT];
               end
            end
            `REG_WD_UNIT: begin
               nxt_st.wd_unit = 16'(wmerge({16'h0000, st_ff.wd_unit},
                                           st_ff.wdata, st_ff.wstrb));
            end
            `REG_STATUS: nxt_st.rsp.bresp = `RESP_OKAY;
            default: nxt_st.rsp.bresp = `RESP_SLVERR;
         endcase
      end
      if (st_ff.rsp.bvalid && axi_req.bready) begin
         nxt_st.rsp.bvalid = 1'b0;
         nxt_st.rsp.awready = 1'b1;
         nxt_st.rsp.wready = 1'b1;
      end

      // read channel: address taken, data one cycle later
      if (axi_req.arvalid && st_ff.rsp.arready) begin
         nxt_st.araddr = axi_req.araddr;
         nxt_st.rsp.arready = 1'b0;
         nxt_st.rd_pend = 1'b1;
      end
      rd_ok = 1'b1;
      case (st_ff.araddr)
         `REG_CTRL: rd = {31'h00000000, st_ff.variant};
         `REG_WD_UNIT: rd = {16'h0000, st_ff.wd_unit};
         `REG_STATUS: rd = {22'h000000, wd_fault, st_ff.pins.reset_oe,
                            st_ff.wake_local, st_ff.wake_irq,
                            st_ff.slew_low, st_ff.tx_en, 1'b0,
                            st_ff.mode};
         default: rd_ok = 1'b0;
      endcase
      if (st_ff.rd_pend) begin
         nxt_st.rd_pend = 1'b0;
         nxt_st.rsp.rvalid = 1'b1;
         nxt_st.rsp.rdata = rd;
         nxt_st.rsp.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (st_ff.rsp.rvalid && axi_req.rready) begin
         nxt_st.rsp.rvalid = 1'b0;
         nxt_st.rsp.arready = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!core_rst_n) st_ff <= ST_RST;
      else st_ff <= nxt_st;
   end

   assign pins_o = st_ff.pins;
   assign axi_rsp = st_ff.rsp;
endmodule // lin_sbc_mode_wake_control
`default_nettype wire

// file: src/lin_sbc_map.svh
/*
 offsets, field positions, reset values and timing counts of the
 LIN system basis controller; included by the design modules.
*/
`ifndef LIN_SBC_MAP_SVH
`define LIN_SBC_MAP_SVH

`define CLK_MHZ        100
`define POR_DELAY_US   4000
`define POR_CYCLES     (`POR_DELAY_US * `CLK_MHZ)
`define STBY_TO_MS     350
`define STBY_CYCLES    (`STBY_TO_MS * 1000 * `CLK_MHZ)
`define EN_DEB_US      10
`define EN_DEB_CYCLES  (`EN_DEB_US * `CLK_MHZ)
`define NORM_DLY_US    10
`define NORM_CYCLES    (`NORM_DLY_US * `CLK_MHZ)
`define DOM_TO_US      6000
`define DOM_CYCLES     (`DOM_TO_US * `CLK_MHZ)
`define WU_REMOTE_US   100
`define WU_CYCLES      (`WU_REMOTE_US * `CLK_MHZ)
`define TMR_W          26

`define REG_CTRL       8'h00
`define REG_WD_UNIT    8'h04
`define REG_STATUS     8'h08
`define CTRL_VARIANT   0
`define CTRL_RST       1'b1
`define WD_UNIT_RST    16'h03E8
`define WD_CLOSED_TKS  8'h0A
`define WD_OPEN_TKS    8'h0A
`define WD_RESET_TKS   8'h02
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// file: src/lin_sbc_pkg.sv
/*
 types of the LIN system basis controller: modes, pin and bus
 carriers and the state records; constants live in lin_sbc_map.svh.
*/
package lin_sbc_pkg;
   typedef enum logic [2:0] {
      M_INIT = 3'b000, M_STANDBY = 3'b001, M_NORM_WAIT = 3'b010,
      M_NORMAL = 3'b011, M_SILENT = 3'b100, M_SLEEP = 3'b101
   } mode_t;
   typedef enum logic [1:0] {
      WD_CLOSED = 2'b00, WD_OPEN = 2'b01, WD_FAULT = 2'b10
   } wd_phase_t;
   typedef struct packed {
      logic [7:0] awaddr; logic awvalid;
      logic [31:0] wdata; logic [3:0] wstrb; logic wvalid;
      logic bready;
      logic [7:0] araddr; logic arvalid; logic rready;
   } axil_req_t;
   typedef struct packed {
      logic awready; logic wready; logic bvalid; logic [1:0] bresp;
      logic arready; logic rvalid; logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;
   typedef struct packed {
      logic enable_in; logic txd_i; logic txd_undriven;
      logic local_wake_in; logic local_wake_open;
      logic ignition_wake_in; logic ignition_open;
      logic wdog_kick_n; logic wdog_mode_in; logic lin_bus_in;
      logic battery_ok; logic vcc_ok;
   } pins_in_t;
   typedef struct packed {
      logic rxd_o; logic rxd_oe; logic txd_o; logic txd_oe;
      logic reset_out_n; logic reset_oe; logic lin_dom;
      logic lin_slew_low; logic supply_inhibit_out; logic vreg_on;
   } pins_out_t;
   typedef struct packed {
      logic [15:0] cnt; logic out;
   } deb_state_t;
   typedef struct packed {
      wd_phase_t phase; logic [15:0] pre; logic [7:0] ticks;
   } wd_state_t;
   typedef struct packed {
      mode_t mode; logic [25:0] tmr; logic en_q; logic first_done;
      logic slew_low; logic tx_en; logic txd_q; logic [25:0] dom_cnt;
      logic wake_irq; logic wake_local; logic lw_q; logic ign_q;
      logic lin_q; logic [25:0] rw_cnt; logic kick_q;
      logic [25:0] por_cnt; logic variant; logic [15:0] wd_unit;
      logic [7:0] awaddr; logic [31:0] wdata; logic [3:0] wstrb;
      logic [7:0] araddr; logic rd_pend;
      pins_out_t pins; axil_rsp_t rsp;
   } sbc_state_t;
endpackage

// file: src/en_debounce.sv
/*
 debounce filter for the enable pin: the output follows the input
 only after it has held a new level for the debounce count.
 assumes inputs synchronous to aclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lin_sbc_map.svh"
module en_debounce (
   input  wire logic aclk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);
   localparam logic [15:0] DEB = 16'(`EN_DEB_CYCLES);
   lin_sbc_pkg::deb_state_t s_ff, nxt_s;

   always_comb begin
      nxt_s = s_ff;
      if (din == s_ff.out) begin
         nxt_s.cnt = 16'h0000;
      end else if (s_ff.cnt == DEB - 16'h0001) begin
         nxt_s.out = din;
         nxt_s.cnt = 16'h0000;
      end else begin
         nxt_s.cnt = s_ff.cnt + 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!rst_n) s_ff <= '0;
      else s_ff <= nxt_s;
   end

   assign dout = s_ff.out;
endmodule // en_debounce
`default_nettype wire

// file: src/window_watchdog.sv
/*
 window watchdog: closed window, open window, then a reset phase on a
 missed or early kick. one tick is unit clock cycles.
 assumes kick is a one-cycle pulse on the trigger falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lin_sbc_map.svh"
module window_watchdog (
   input  wire logic        aclk,
   input  wire logic        rst_n,
   input  wire logic        run,
   input  wire logic        kick,
   input  wire logic [15:0] unit,
   output logic             fault_rst
);
   lin_sbc_pkg::wd_state_t s_ff, nxt_s;

   always_comb begin
      logic tick;
      tick = (s_ff.pre >= unit - 16'h0001);
      nxt_s = s_ff;
      nxt_s.pre = tick ? 16'h0000 : s_ff.pre + 16'h0001;
      case (s_ff.phase)
         lin_sbc_pkg::WD_CLOSED: begin
            if (kick) begin
               nxt_s.phase = lin_sbc_pkg::WD_FAULT;
               nxt_s.ticks = 8'h00;
            end else if (tick) begin
               if (s_ff.ticks == `WD_CLOSED_TKS - 8'h01) begin
                  nxt_s.phase = lin_sbc_pkg::WD_OPEN;
                  nxt_s.ticks = 8'h00;
               end else nxt_s.ticks = s_ff.ticks + 8'h01;
            end
         end
         lin_sbc_pkg::WD_OPEN: begin
            if (kick) begin
               nxt_s.phase = lin_sbc_pkg::WD_CLOSED;
               nxt_s.ticks = 8'h00;
               nxt_s.pre = 16'h0000;
            end else if (tick) begin
               if (s_ff.ticks == `WD_OPEN_TKS - 8'h01) begin
                  nxt_s.phase = lin_sbc_pkg::WD_FAULT;
                  nxt_s.ticks = 8'h00;
               end else nxt_s.ticks = s_ff.ticks + 8'h01;
            end
         end
         lin_sbc_pkg::WD_FAULT: begin
            if (tick) begin
               if (s_ff.ticks == `WD_RESET_TKS - 8'h01) begin
                  nxt_s.phase = lin_sbc_pkg::WD_CLOSED;
                  nxt_s.ticks = 8'h00;
               end else nxt_s.ticks = s_ff.ticks + 8'h01;
            end
         end
         default: nxt_s.phase = lin_sbc_pkg::WD_CLOSED;
      endcase
      // a fault phase already begun runs to its end
      if (!run && s_ff.phase != lin_sbc_pkg::WD_FAULT) nxt_s = '0;
   end

   always_ff @(posedge aclk) begin
      if (!rst_n) s_ff <= '0;
      else s_ff <= nxt_s;
   end

   assign fault_rst = (s_ff.phase == lin_sbc_pkg::WD_FAULT);
endmodule // window_watchdog
`default_nettype wire

// file: tb/lin_sbc_assertions.sv
/*
 port checker for lin_sbc_mode_wake_control.
 assumes it is bound to the top module by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module lin_sbc_assertions #(
   parameter logic [25:0] POR_CYCLES = 26'h32,
   parameter logic [25:0] DOM_CYCLES = 26'h28
) (
   input wire logic                   aclk,
   input wire logic                   aresetn,
   input wire lin_sbc_pkg::pins_in_t  pins_i,
   input wire lin_sbc_pkg::axil_req_t axi_req,
   input wire lin_sbc_pkg::pins_out_t pins_o,
   input wire lin_sbc_pkg::axil_rsp_t axi_rsp
);
   logic [25:0] por_cnt;
   logic [25:0] dom_cnt;
   logic        rst;
   logic        tx_low;
   assign rst = !aresetn || !pins_i.battery_ok;
   assign tx_low = !pins_i.txd_i && !pins_i.txd_undriven;
   // both counters saturate so a long run cannot wrap into a pass
   always_ff @(posedge aclk) begin
      if (rst) begin
         por_cnt <= '0;
         dom_cnt <= '0;
      end else begin
         if (pins_i.vcc_ok && por_cnt != '1)
            por_cnt <= por_cnt + 26'h1;
         dom_cnt <= !tx_low ? '0 : (dom_cnt == '1 ? dom_cnt : dom_cnt + 26'h1);
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (rst);
   a_uv_reset: assert property (disable iff (!aresetn)
      !pins_i.battery_ok |=> pins_o.reset_oe && !pins_o.supply_inhibit_out)
      else $error("undervoltage did not hold reset");
   a_dom_cause: assert property (
      pins_o.lin_dom |-> $past(tx_low))
      else $error("bus dominant without dominant transmit input");
   a_dom_limit: assert property (
      pins_o.lin_dom |-> dom_cnt <= DOM_CYCLES + 26'h2)
      else $error("dominant time-out not applied");
   a_por_hold: assert property (
      $fell(pins_o.reset_oe) |-> por_cnt >= POR_CYCLES - 26'h1)
      else $error("reset output released early");
   a_inh_vreg: assert property (
      pins_o.supply_inhibit_out |-> pins_o.vreg_on)
      else $error("inhibit on with regulator off");
   a_wd_off: assert property (
      pins_i.wdog_mode_in && $past(pins_i.wdog_mode_in) && pins_i.vcc_ok
      && $past(pins_i.vcc_ok) |-> !$rose(pins_o.reset_oe))
      else $error("watchdog fault while disabled");
   a_b_latency: assert property (axi_req.awvalid && axi_rsp.awready
      && axi_req.wvalid && axi_rsp.wready |-> ##2 axi_rsp.bvalid)
      else $error("write response late");
   a_r_latency: assert property (
      axi_req.arvalid && axi_rsp.arready |-> ##2 axi_rsp.rvalid)
      else $error("read response late");
   a_r_unmapped: assert property (axi_req.arvalid && axi_rsp.arready
      && axi_req.araddr > 8'h08 |-> ##2 axi_rsp.rresp == 2'h2)
      else $error("unmapped read not refused");
endmodule // lin_sbc_assertions
`default_nettype wire

// file: tb/lin_far_node.sv
/*
 far side of the LIN bus: pull-up plus one node that can hold the bus
 dominant long enough for a remote wake. assumes aclk of the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module lin_far_node #(
   parameter int HOLD = 30
) (
   input wire logic aclk,
   input wire logic wake_req,
   input wire logic lin_dom,
   output logic     lin_bus_in
);
   int cnt = 0;
   // wired-and with pull-up: recessive unless someone drives dominant
   assign lin_bus_in = !(lin_dom || cnt != 0);
   always @(posedge aclk) begin
      if (wake_req && cnt == 0)
         cnt <= HOLD;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
endmodule // lin_far_node
`default_nettype wire

// file: tb/test_lin_sbc_mode_wake_control.sv
/*
 bench for lin_sbc_mode_wake_control: AXI4-Lite tasks and pin stimulus.
 assumes shortened parameters and the far node model.
*/
`timescale 1ns/100ps
`default_nettype none
module test_lin_sbc_mode_wake_control;
   logic                   aclk;
   logic                   aresetn;
   logic                   wake_req;
   logic                   bus;
   lin_sbc_pkg::pins_in_t  drv;
   lin_sbc_pkg::pins_in_t  pins;
   lin_sbc_pkg::axil_req_t req;
   lin_sbc_pkg::pins_out_t po;
   lin_sbc_pkg::axil_rsp_t rsp;
   logic [31:0]            d;
   logic [1:0]             r;
   int                     miscompares = 0;
   int                     comparisons = 0;
   int                     cyc = 0;
   always_comb begin
      pins = drv;
      pins.lin_bus_in = bus;
   end
   lin_sbc_mode_wake_control #(.POR_CYCLES(26'h32),
      .STBY_CYCLES(26'hBB8), .DOM_CYCLES(26'h28), .WU_CYCLES(26'h14))
      u_dut (.aclk(aclk), .aresetn(aresetn), .pins_i(pins),
      .axi_req(req), .pins_o(po), .axi_rsp(rsp));
   lin_far_node #(.HOLD(30)) u_far (.aclk(aclk), .wake_req(wake_req),
      .lin_dom(po.lin_dom), .lin_bus_in(bus));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic give_verdict;
      $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cy(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      req.awaddr <= a;
      req.wdata <= v;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      r = rsp.bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      d = rsp.rdata;
      r = rsp.rresp;
   endtask
   task automatic st(input logic [2:0] m);
      rd(8'h08);
      check(d & 32'h7, 32'(m));
   endtask
   task automatic wait_oe(input logic v);
      int n;
      n = 0;
      while (po.reset_oe !== v && n < 200) begin
         @(posedge aclk);
         n++;
      end
      check(32'(po.reset_oe), 32'(v));
   endtask
   initial begin
      aresetn = 1'b0;
      wake_req = 1'b0;
      req = '0;
      req.wstrb = 4'hF;
      req.bready = 1'b1;
      req.rready = 1'b1;
      drv = '0;
      drv.enable_in = 1'b1;
      drv.battery_ok = 1'b1;
      drv.vcc_ok = 1'b1;
      drv.wdog_kick_n = 1'b1;
      drv.wdog_mode_in = 1'b1;
      drv.local_wake_in = 1'b1;
      cy(5);
      aresetn <= 1'b1;
      wr(8'h08, 32'h0);
      check(32'(r), 32'h0);
      rd(8'h08);
      check(d & 32'h107, 32'h101);
      rd(8'h00);
      check(d, 32'h1);
      rd(8'h04);
      check(d, 32'h3E8);
      rd(8'h0C);
      check(d | 32'(r), 32'h2);
      cy(50);
      check(32'(po.reset_oe), 32'h0);
      check(32'({po.rxd_o, po.txd_o, po.reset_out_n}), 32'h0);
      $display("registers and power-up done");
      drv.enable_in <= 1'b0;
      cy(10);
      drv.enable_in <= 1'b1;
      cy(950);
      st(3'h1);
      cy(140);
      st(3'h2);
      cy(1000);
      st(3'h3);
      check(d & 32'h30, 32'h20);
      check(32'(po.lin_slew_low), 32'h1);
      drv.txd_undriven <= 1'b1;
      cy(3);
      rd(8'h08);
      check(d & 32'h10, 32'h10);
      drv.txd_undriven <= 1'b0;
      cy(3);
      check(32'({po.lin_dom, po.rxd_oe}), 32'h3);
      cy(50);
      check(32'(po.lin_dom), 32'h0);
      drv.txd_i <= 1'b1;
      cy(3);
      drv.txd_i <= 1'b0;
      cy(30);
      drv.txd_i <= 1'b1;
      cy(1);
      drv.txd_i <= 1'b0;
      cy(30);
      check(32'(po.lin_dom), 32'h1);
      drv.txd_i <= 1'b1;
      $display("transmit done");
      wr(8'h04, 32'h2);
      drv.wdog_mode_in <= 1'b0;
      wait_oe(1'b1);
      wait_oe(1'b0);
      repeat (4) begin
         cy(30);
         drv.wdog_kick_n <= 1'b0;
         cy(2);
         drv.wdog_kick_n <= 1'b1;
         check(32'(po.reset_oe), 32'h0);
      end
      wait_oe(1'b1);
      drv.wdog_mode_in <= 1'b1;
      wait_oe(1'b0);
      $display("watchdog done");
      drv.enable_in <= 1'b0;
      cy(1100);
      st(3'h4);
      check(32'(po.supply_inhibit_out), 32'h0);
      drv.ignition_wake_in <= 1'b1;
      cy(3);
      st(3'h1);
      check(32'({po.rxd_oe, po.txd_oe}), 32'h3);
      drv.ignition_wake_in <= 1'b0;
      cy(3010);
      st(3'h5);
      check(32'(po.vreg_on), 32'h0);
      drv.local_wake_in <= 1'b0;
      cy(3);
      st(3'h1);
      check(32'({po.rxd_oe, po.txd_oe}), 32'h3);
      drv.local_wake_in <= 1'b1;
      drv.enable_in <= 1'b1;
      cy(1003);
      check(32'({po.rxd_oe, po.txd_oe}), 32'h0);
      rd(8'h08);
      check(d & 32'hC0, 32'h0);
      cy(1000);
      st(3'h3);
      drv.txd_i <= 1'b0;
      drv.enable_in <= 1'b0;
      cy(1100);
      st(3'h5);
      wake_req <= 1'b1;
      cy(1);
      wake_req <= 1'b0;
      cy(40);
      st(3'h1);
      check(32'({po.rxd_oe, po.txd_oe}), 32'h2);
      wr(8'h00, 32'h0);
      cy(3010);
      drv.local_wake_in <= 1'b0;
      cy(5);
      st(3'h5);
      $display("modes and wakes done");
      drv.battery_ok <= 1'b0;
      cy(2);
      check(32'({po.reset_oe, po.supply_inhibit_out}), 32'h2);
      drv.battery_ok <= 1'b1;
      cy(2);
      st(3'h1);
      $display("undervoltage done");
      give_verdict();
   end
endmodule // test_lin_sbc_mode_wake_control
bind lin_sbc_mode_wake_control lin_sbc_assertions #(
   .POR_CYCLES(POR_CYCLES), .DOM_CYCLES(DOM_CYCLES)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .pins_i(pins_i), .axi_req(axi_req),
   .pins_o(pins_o), .axi_rsp(axi_rsp));
`default_nettype wire
